/* vreg_pkg.sv */
// Package for the regulator voltage code bank: register offsets, field
// layouts, decode constants and the carrier structs.
// Assumes a byte-wide register port driven by the serial bus decoder.

package vreg_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] BUCK1_NORMAL_OFFSET = 8'h20;
  localparam logic [7:0] BUCK1_SCALED_OFFSET = 8'h21;
  localparam logic [7:0] BUCK2_NORMAL_OFFSET = 8'h22;
  localparam logic [7:0] BUCK2_SCALED_OFFSET = 8'h23;
  localparam logic [7:0] LDO3_OFFSET         = 8'h26;
  localparam logic [7:0] LDO4_OFFSET         = 8'h27;

  // ------------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------------
  localparam int         LINEAR_CODE_MSB   = 5;
  localparam logic [7:0] LINEAR_CODE_MASK  = 8'h3f;
  localparam logic [7:0] BUCK_CODE_RESET   = 8'h00;
  localparam logic [5:0] LINEAR_CODE_RESET = 6'h00;

  // ------------------------------------------------------------------
  // Decode: linear targets in millivolts, buck targets in 0.1 mV
  // ------------------------------------------------------------------
  localparam logic [7:0]  BUCK_SAT_CODE   = 8'hd8;
  localparam logic [15:0] BUCK_BASE_UV    = 16'd600;
  localparam logic [15:0] BUCK_MAX_UV     = 16'd3300;
  localparam logic [5:0]  LINEAR_SAT_CODE = 6'h2e;
  localparam logic [15:0] LINEAR_BASE_MV  = 16'd1000;
  localparam logic [15:0] LINEAR_STEP_MV  = 16'd50;
  localparam logic [15:0] LINEAR_MAX_MV   = 16'd3300;

  // Buck targets are in units of 0.1 mV so the 12.5 mV step is exact
  localparam logic [15:0] BUCK_BASE_TENTH = 16'd6000;
  localparam logic [15:0] BUCK_STEP_TENTH = 16'd125;
  localparam logic [15:0] BUCK_MAX_TENTH  = 16'd33000;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] buck1_normal;
    logic [15:0] buck1_scaled;
    logic [15:0] buck2_normal;
    logic [15:0] buck2_scaled;
    logic [15:0] ldo3;
    logic [15:0] ldo4;
  } targets_t;

endpackage

/* vreg_decode.sv */
// Combinational code-to-target decoder for one converter or regulator.
// Assumes the code is held stable in a register by the caller.

`timescale 1ns/1ps
`default_nettype none

module vreg_decode (
  input  wire logic        linear,
  input  wire logic [7:0]  code,
  output logic      [15:0] target
);

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  always_comb begin
    target = 16'h0000;
    if (linear) begin
      if (code[5:0] >= vreg_pkg::LINEAR_SAT_CODE) begin
        target = vreg_pkg::LINEAR_MAX_MV;
      end else begin
        target = vreg_pkg::LINEAR_BASE_MV
               + 16'(code[5:0]) * vreg_pkg::LINEAR_STEP_MV;
      end
    end else begin
      // Saturate rather than let the product run past the range
      if (code >= vreg_pkg::BUCK_SAT_CODE) begin
        target = vreg_pkg::BUCK_MAX_TENTH;
      end else begin
        target = vreg_pkg::BUCK_BASE_TENTH
               + 16'(code) * vreg_pkg::BUCK_STEP_TENTH;
      end
    end
  end

endmodule

`default_nettype wire

/* vreg_regs.sv */
// Register bank holding the converter and regulator voltage codes and
// the decoded targets fed to the analog loops.
// Assumes a serial bus decoder on ref_clk presenting one-cycle requests.

`timescale 1ns/1ps
`default_nettype none

module vreg_regs (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire vreg_pkg::reg_req_t req,
  output logic      [7:0]        rdata,
  output vreg_pkg::targets_t     targets
);

  logic [7:0] buck1_normal_voltage_code;
  logic [7:0] buck1_scaled_voltage_code;
  logic [7:0] buck2_normal_voltage_code;
  logic [7:0] buck2_scaled_voltage_code;
  logic [5:0] ldo3_voltage_code;
  logic [5:0] ldo4_voltage_code;
  logic [7:0] next_b1n;
  logic [7:0] next_b1s;
  logic [7:0] next_b2n;
  logic [7:0] next_b2s;
  logic [5:0] next_ldo3;
  logic [5:0] next_ldo4;
  logic [7:0] next_rdata;
  vreg_pkg::targets_t next_targets;
  logic [15:0] dec [6];

  // ------------------------------------------------------------------
  // Write path
  // ------------------------------------------------------------------
  always_comb begin
    next_b1n  = buck1_normal_voltage_code;
    next_b1s  = buck1_scaled_voltage_code;
    next_b2n  = buck2_normal_voltage_code;
    next_b2s  = buck2_scaled_voltage_code;
    next_ldo3 = ldo3_voltage_code;
    next_ldo4 = ldo4_voltage_code;
    if (req.wr) begin
      case (req.addr)
        vreg_pkg::BUCK1_NORMAL_OFFSET: next_b1n = req.wdata;
        vreg_pkg::BUCK1_SCALED_OFFSET: next_b1s = req.wdata;
        vreg_pkg::BUCK2_NORMAL_OFFSET: next_b2n = req.wdata;
        vreg_pkg::BUCK2_SCALED_OFFSET: next_b2s = req.wdata;
        // Upper bits are dropped, never stored
        vreg_pkg::LDO3_OFFSET: next_ldo3 = req.wdata[5:0];
        vreg_pkg::LDO4_OFFSET: next_ldo4 = req.wdata[5:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Read path; unmapped offsets read zero
  // ------------------------------------------------------------------
  always_comb begin
    case (req.addr)
      vreg_pkg::BUCK1_NORMAL_OFFSET: next_rdata = buck1_normal_voltage_code;
      vreg_pkg::BUCK1_SCALED_OFFSET: next_rdata = buck1_scaled_voltage_code;
      vreg_pkg::BUCK2_NORMAL_OFFSET: next_rdata = buck2_normal_voltage_code;
      vreg_pkg::BUCK2_SCALED_OFFSET: next_rdata = buck2_scaled_voltage_code;
      vreg_pkg::LDO3_OFFSET: next_rdata = {2'b00, ldo3_voltage_code};
      vreg_pkg::LDO4_OFFSET: next_rdata = {2'b00, ldo4_voltage_code};
      default: next_rdata = 8'h00;
    endcase
  end

  // ------------------------------------------------------------------
  // Decoders; outputs registered so the analog side sees clean steps
  // ------------------------------------------------------------------
  vreg_decode u_dec0 (.linear(1'b0), .code(buck1_normal_voltage_code),
                      .target(dec[0]));
  vreg_decode u_dec1 (.linear(1'b0), .code(buck1_scaled_voltage_code),
                      .target(dec[1]));
  vreg_decode u_dec2 (.linear(1'b0), .code(buck2_normal_voltage_code),
                      .target(dec[2]));
  vreg_decode u_dec3 (.linear(1'b0), .code(buck2_scaled_voltage_code),
                      .target(dec[3]));
  vreg_decode u_dec4 (.linear(1'b1), .code({2'b00, ldo3_voltage_code}),
                      .target(dec[4]));
  vreg_decode u_dec5 (.linear(1'b1), .code({2'b00, ldo4_voltage_code}),
                      .target(dec[5]));

  always_comb begin
    next_targets = '{buck1_normal: dec[0], buck1_scaled: dec[1],
                     buck2_normal: dec[2], buck2_scaled: dec[3],
                     ldo3: dec[4], ldo4: dec[5]};
  end

  // Code registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      buck1_normal_voltage_code <= vreg_pkg::BUCK_CODE_RESET;
      buck1_scaled_voltage_code <= vreg_pkg::BUCK_CODE_RESET;
      buck2_normal_voltage_code <= vreg_pkg::BUCK_CODE_RESET;
      buck2_scaled_voltage_code <= vreg_pkg::BUCK_CODE_RESET;
      ldo3_voltage_code         <= vreg_pkg::LINEAR_CODE_RESET;
      ldo4_voltage_code         <= vreg_pkg::LINEAR_CODE_RESET;
    end else begin
      buck1_normal_voltage_code <= next_b1n;
      buck1_scaled_voltage_code <= next_b1s;
      buck2_normal_voltage_code <= next_b2n;
      buck2_scaled_voltage_code <= next_b2s;
      ldo3_voltage_code         <= next_ldo3;
      ldo4_voltage_code         <= next_ldo4;
    end
  end

  // Read data and decoded targets
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata   <= 8'h00;
      targets <= '0;
    end else begin
      rdata   <= next_rdata;
      targets <= next_targets;
    end
  end

  // ------------------------------------------------------------------
  // Checks: a write lands in its code at the next edge and in the
  // registered target one edge later, hence the two-cycle delays
  // ------------------------------------------------------------------
  a_buck_step: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (req.wr && req.addr == vreg_pkg::BUCK1_NORMAL_OFFSET
     && req.wdata < vreg_pkg::BUCK_SAT_CODE)
    |-> ##2 targets.buck1_normal == vreg_pkg::BUCK_BASE_TENTH
        + 16'($past(req.wdata, 2)) * vreg_pkg::BUCK_STEP_TENTH)
    else $error("buck target not linear");
  a_buck_scaled: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (req.wr && req.addr == vreg_pkg::BUCK2_SCALED_OFFSET
     && req.wdata < vreg_pkg::BUCK_SAT_CODE)
    |-> ##2 targets.buck2_scaled == vreg_pkg::BUCK_BASE_TENTH
        + 16'($past(req.wdata, 2)) * vreg_pkg::BUCK_STEP_TENTH)
    else $error("scaled buck target not linear");
  a_buck_zero: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (req.wr && req.addr == vreg_pkg::BUCK2_NORMAL_OFFSET
     && req.wdata == 8'h00)
    |-> ##2 targets.buck2_normal == vreg_pkg::BUCK_BASE_TENTH)
    else $error("buck code zero not lowest target");
  a_buck_sat: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (req.wr && req.addr == vreg_pkg::BUCK1_SCALED_OFFSET
     && req.wdata >= vreg_pkg::BUCK_SAT_CODE)
    |-> ##2 targets.buck1_scaled == vreg_pkg::BUCK_MAX_TENTH)
    else $error("buck target not saturated");
  a_buck2_sat: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (req.wr && req.addr == vreg_pkg::BUCK2_NORMAL_OFFSET
     && req.wdata >= vreg_pkg::BUCK_SAT_CODE)
    |-> ##2 targets.buck2_normal == vreg_pkg::BUCK_MAX_TENTH)
    else $error("second buck target not saturated");
  // A wrapped or unsaturated top code would land above the ceiling
  a_buck_ceiling: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    targets.buck1_normal <= vreg_pkg::BUCK_MAX_TENTH
    && targets.buck1_scaled <= vreg_pkg::BUCK_MAX_TENTH
    && targets.buck2_normal <= vreg_pkg::BUCK_MAX_TENTH
    && targets.buck2_scaled <= vreg_pkg::BUCK_MAX_TENTH)
    else $error("buck target above range");
  a_ldo3_read: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (req.wr && req.addr == vreg_pkg::LDO3_OFFSET)
    ##1 (!req.wr && req.addr == vreg_pkg::LDO3_OFFSET)
    |-> ##1 rdata == {2'b00, $past(req.wdata[5:0], 2)})
    else $error("ldo3 readback wrong");
  a_ldo3_hold: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !(req.wr && req.addr == vreg_pkg::LDO3_OFFSET)
    |=> $stable(ldo3_voltage_code))
    else $error("ldo3 code changed without its write");
  a_ldo4_read: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (req.wr && req.addr == vreg_pkg::LDO4_OFFSET)
    ##1 (!req.wr && req.addr == vreg_pkg::LDO4_OFFSET)
    |-> ##1 rdata == {2'b00, $past(req.wdata[5:0], 2)})
    else $error("ldo4 readback wrong");
  a_ldo4_hold: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !(req.wr && req.addr == vreg_pkg::LDO4_OFFSET)
    |=> $stable(ldo4_voltage_code))
    else $error("ldo4 code changed without its write");
  a_ldo_step: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (req.wr && req.addr == vreg_pkg::LDO3_OFFSET
     && req.wdata[5:0] < vreg_pkg::LINEAR_SAT_CODE)
    |-> ##2 targets.ldo3 == vreg_pkg::LINEAR_BASE_MV
        + 16'($past(req.wdata[5:0], 2)) * vreg_pkg::LINEAR_STEP_MV)
    else $error("ldo3 target not linear");
  a_ldo4_step: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (req.wr && req.addr == vreg_pkg::LDO4_OFFSET
     && req.wdata[5:0] < vreg_pkg::LINEAR_SAT_CODE)
    |-> ##2 targets.ldo4 == vreg_pkg::LINEAR_BASE_MV
        + 16'($past(req.wdata[5:0], 2)) * vreg_pkg::LINEAR_STEP_MV)
    else $error("ldo4 target not linear");
  a_ldo_sat: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (req.wr && req.addr == vreg_pkg::LDO4_OFFSET
     && req.wdata[5:0] >= vreg_pkg::LINEAR_SAT_CODE)
    |-> ##2 targets.ldo4 == vreg_pkg::LINEAR_MAX_MV)
    else $error("ldo4 target not saturated");
  a_ldo3_sat: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (req.wr && req.addr == vreg_pkg::LDO3_OFFSET
     && req.wdata[5:0] >= vreg_pkg::LINEAR_SAT_CODE)
    |-> ##2 targets.ldo3 == vreg_pkg::LINEAR_MAX_MV)
    else $error("ldo3 target not saturated");
  a_ldo_ceiling: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    targets.ldo3 <= vreg_pkg::LINEAR_MAX_MV
    && targets.ldo4 <= vreg_pkg::LINEAR_MAX_MV)
    else $error("ldo target above range");
  a_spare_zero: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ($past(req.addr) == vreg_pkg::LDO3_OFFSET
     || $past(req.addr) == vreg_pkg::LDO4_OFFSET)
    |-> rdata[7:6] == 2'b00)
    else $error("spare bits not zero");

endmodule

`default_nettype wire

/* vreg_host_model.sv */
// Host-side model issuing byte register writes and reads on ref_clk.
// Assumes callers enter each task just after a rising clock edge.

`timescale 1ns/1ps
`default_nettype none

module vreg_host_model (
  input  wire logic               ref_clk,
  input  wire logic [7:0]         rdata,
  output var  vreg_pkg::reg_req_t req
);
  // ------------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------------
  initial req = '0;

  // Strobe stays high on return so back-to-back writes never toggle it
  // within one time step; a read must always close a run of writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    #1;
  endtask

  // Stale write data is inverted so nothing can lean on its last value
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req = '{wr: 1'b0, addr: a, wdata: ~req.wdata};
    @(posedge ref_clk);
    #1 d = rdata;
  endtask
endmodule

`default_nettype wire

/* vreg_regs_tb_top.sv */
// Self-checking bench for the voltage code register bank.
// Assumes the host model drives requests 1 ns after each rising edge.

`timescale 1ns/1ps
`default_nettype none

module vreg_regs_tb_top;
  logic               ref_clk = 1'b0;
  logic               rstn    = 1'b0;
  vreg_pkg::reg_req_t req;
  logic [7:0]         rdata;
  vreg_pkg::targets_t targets;
  int                 n_fail          = 0;
  int                 samples_checked = 0;
  logic [7:0]         boff [4] = '{8'h20, 8'h21, 8'h22, 8'h23};
  logic [7:0]         loff [2] = '{8'h26, 8'h27};

  always #20 ref_clk = ~ref_clk;

  vreg_regs i_vreg_regs (.ref_clk(ref_clk), .rstn(rstn), .req(req),
                         .rdata(rdata), .targets(targets));
  vreg_host_model i_vreg_host_model (.ref_clk(ref_clk), .rdata(rdata),
                                     .req(req));

  // ------------------------------------------------------------------
  // Expectations and compares
  // ------------------------------------------------------------------
  // Buck targets in 0.1 mV: 6000 + 125 per code, 33000 at saturation
  function automatic logic [15:0] buck_exp(input logic [7:0] c);
    return (c >= 8'hd8) ? 16'h80e8 : 16'h1770 + 16'h007d * c;
  endfunction

  // Linear targets in mV: 1000 + 50 per code, 3300 at saturation
  function automatic logic [15:0] lin_exp(input logic [7:0] c);
    return (c >= 8'h2e) ? 16'h0ce4 : 16'h03e8 + 16'h0032 * c;
  endfunction

  function automatic logic [15:0] field(input logic [7:0] a);
    case (a)
      8'h20: return targets.buck1_normal;
      8'h21: return targets.buck1_scaled;
      8'h22: return targets.buck2_normal;
      8'h23: return targets.buck2_scaled;
      8'h26: return targets.ldo3;
      8'h27: return targets.ldo4;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic chk8(input string w, input logic [7:0] e,
                      input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic chk16(input string w, input logic [15:0] e,
                       input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic reset_state();
    chk8("rdata after reset", 8'h00, rdata);
    foreach (boff[i]) begin
      chk16("buck reset target", 16'h1770, field(boff[i]));
    end
    foreach (loff[i]) begin
      chk16("ldo reset target", 16'h03e8, field(loff[i]));
    end
  endtask

  // Reset in mid-run must bring every code back to zero
  task automatic reset_again();
    logic [7:0] d;
    rstn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 rstn = 1'b1;
    @(posedge ref_clk);
    #1;
    reset_state();
    i_vreg_host_model.rd(8'h23, d);
    chk8("buck code after reset", 8'h00, d);
  endtask

  task automatic buck_codes();
    logic [7:0] codes [6] = '{8'h00, 8'h2a, 8'hd7, 8'hd8, 8'hea, 8'hff};
    logic [7:0] d;
    logic [15:0] e;
    foreach (boff[i]) foreach (codes[j]) begin
      i_vreg_host_model.wr(boff[i], codes[j]);
      i_vreg_host_model.rd(boff[i], d);
      chk8("buck readback", codes[j], d);
      e = buck_exp(codes[j]);
      chk16("buck target", e, field(boff[i]));
    end
  endtask

  // Upper bits are set on every write to show they are dropped
  task automatic ldo_codes();
    logic [7:0] codes [5] = '{8'h00, 8'h15, 8'h2d, 8'h2e, 8'h3f};
    logic [7:0] d;
    foreach (loff[i]) foreach (codes[j]) begin
      i_vreg_host_model.wr(loff[i], codes[j] | 8'hc0);
      i_vreg_host_model.rd(loff[i], d);
      chk8("linear readback", codes[j], d);
      chk16("linear target", lin_exp(codes[j]), field(loff[i]));
    end
  endtask

  task automatic back_to_back();
    logic [7:0] d;
    i_vreg_host_model.wr(8'h26, 8'h01);
    i_vreg_host_model.wr(8'h27, 8'h2c);
    i_vreg_host_model.wr(8'h24, 8'h55);
    i_vreg_host_model.rd(8'h24, d);
    chk8("unmapped read", 8'h00, d);
    i_vreg_host_model.rd(8'h26, d);
    chk8("ldo3 kept", 8'h01, d);
    i_vreg_host_model.rd(8'h27, d);
    chk8("ldo4 kept", 8'h2c, d);
    chk16("ldo4 target", 16'h0c80, targets.ldo4);
  endtask

  // ------------------------------------------------------------------
  // Sequence and verdict
  // ------------------------------------------------------------------
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    #1 rstn = 1'b1;
    @(posedge ref_clk);
    #1;
    reset_state();
    buck_codes();
    ldo_codes();
    back_to_back();
    reset_again();
    give_verdict();
  end

  // Guards against a hang anywhere in the sequence
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_fail++;
    give_verdict();
  end
endmodule

`default_nettype wire
